// ===== nvmac_cfg.svh
`ifndef NVMAC_CFG_SVH
`define NVMAC_CFG_SVH
// register byte addresses on the AXI4-Lite bus
`define NVMAC_OFS_DATA_LO 8'h00
`define NVMAC_OFS_DATA_HI 8'h04
`define NVMAC_OFS_ADDR_LO 8'h08
`define NVMAC_OFS_ADDR_HI 8'h0c
`define NVMAC_OFS_CTRL 8'h10
`define NVMAC_OFS_KEY 8'h14
`define NVMAC_OFS_STATUS 8'h18
// control field positions
`define NVMAC_B_FLASH 7
`define NVMAC_B_IDSP 6
`define NVMAC_B_LATCH 5
`define NVMAC_B_ERASE 4
`define NVMAC_B_FAULT 3
`define NVMAC_B_MODEN 2
`define NVMAC_B_PROG 1
`define NVMAC_B_FETCH 0
// unlock keys
`define NVMAC_KEY1 8'h55
`define NVMAC_KEY2 8'haa
// reset values
`define NVMAC_RST_CTRL 8'h00
`define NVMAC_ADDR_HI_TOP 1'b1
// id space map
`define NVMAC_ID_USER_LO 15'h0000
`define NVMAC_ID_USER_HI 15'h0003
`define NVMAC_ID_DEVID 15'h0006
`define NVMAC_ID_CFG_LO 15'h0007
`define NVMAC_ID_CFG_HI 15'h0008
// timing
`define NVMAC_CLK_HZ 20000000
`define NVMAC_PROG_TIME_US 2000
`define NVMAC_PROG_CYC ((`NVMAC_PROG_TIME_US * (`NVMAC_CLK_HZ / 1000)) / 1000)
`define NVMAC_SETUP_CYC 2
`endif

// ===== nvmac_pkg.sv
package nvmac_pkg;
   typedef enum logic [2:0] {
      NVMAC_IDLE = 3'b000,
      NVMAC_SETUP = 3'b001,
      NVMAC_ERASE = 3'b011,
      NVMAC_WRITE = 3'b010,
      NVMAC_DONE = 3'b110
   } nvmac_state_e;
   typedef enum logic [1:0] {
      NVMAC_SP_EEPROM = 2'b00,
      NVMAC_SP_FLASH = 2'b01,
      NVMAC_SP_ID = 2'b10
   } nvmac_space_e;
   // request to the array
   typedef struct packed {
      logic rd;
      logic erase;
      logic write;
      logic latch;
      nvmac_space_e space;
      logic [14:0] addr;
      logic [13:0] wdata;
   } nvmac_req_s;
endpackage : nvmac_pkg

// ===== nvmac_top.sv
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
// How it works
// - id_space_select steers accesses to the id and configuration region
// - user ids read and write; device id and configuration words read only
// - a read outside the permitted id addresses clears both data registers
// - data is 14 bits; high data bits 7..6 read zero
// - address is 15 bits; high address bit 7 reads one
// - without id space, flash_space_select picks flash, else data eeprom
// - flash or id space with latch_fill_only: trigger only loads a latch
// - flash or id space without latch_fill_only: load latch then program
// - eeprom ignores latch_fill_only; every trigger writes
// - erase_select without latch_fill_only makes the trigger erase a row; hardware clears it after
// - eeprom ignores erase_select; each trigger erases then writes
// - fault flag set on bad sequence, abnormal end, or any trigger set attempt
// - modify_enable clear blocks every program and erase cycle
// - trigger starts a self-timed operation; hardware clears it at the end
// - software can only set the trigger; writing zero has no effect
// - fetch_trigger reads one word in one cycle then clears itself
// - keys 55h then aah must directly precede the trigger
// - two setup cycles, then array ops stall the cpu; latch loads do not
`include "nvmac_cfg.svh"
module nvmac_top import nvmac_pkg::*; #(
   parameter int PROG_CYC = `NVMAC_PROG_CYC,
   parameter int SETUP_CYC = `NVMAC_SETUP_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // array side
   output nvmac_req_s nvm_req_o,
   input wire logic [13:0] nvm_rdata_i,
   input wire logic nvm_abort_i,
   output logic cpu_stall_o
);
   localparam int CW = 17;
   logic [7:0] data_lo_r;
   logic [5:0] data_hi_r;
   logic [7:0] addr_lo_r;
   logic [6:0] addr_hi_r;
   logic flash_r, idsp_r, latch_r, erase_r, fault_r, moden_r, prog_r, fetch_r;
   logic [1:0] key_r; // 0 none, 1 got 55h, 2 unlocked
   nvmac_state_e state_r;
   logic [CW-1:0] cnt_r;
   logic arr_op_r; // accepted op touches the array
   logic latch_only_r, ee_r;
   logic aw_r, w_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_go, wr_hit;
   logic [14:0] addr;
   nvmac_space_e space;
   logic id_ok_rd, id_ok_wr, trig_set, ctrl_wr, accept;
   logic [7:0] rd_val;
   logic rd_hit;

   assign addr = {addr_hi_r, addr_lo_r};
   // space decode
   always_comb begin
      if (idsp_r) begin
         space = NVMAC_SP_ID;
      end else if (flash_r) begin
         space = NVMAC_SP_FLASH;
      end else begin
         space = NVMAC_SP_EEPROM;
      end
   end
   // permitted id addresses
   assign id_ok_rd = (addr <= `NVMAC_ID_USER_HI) || ((addr >= `NVMAC_ID_DEVID)
      && (addr <= `NVMAC_ID_CFG_HI));
   assign id_ok_wr = (addr <= `NVMAC_ID_USER_HI);

   // axi write address/data capture, either order
   assign wr_go = aw_r && w_r && !s_axi_bvalid;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aw_r <= 1'b0;
         w_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_r && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_r && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (wr_go) begin
            w_r <= 1'b0;
         end
      end
   end
   // write response; unmapped gives slverr
   always_comb begin
      wr_hit = 1'b1;
      if (awaddr_r == `NVMAC_OFS_DATA_LO) begin
         wr_hit = 1'b1;
      end else if (awaddr_r == `NVMAC_OFS_DATA_HI) begin
         wr_hit = 1'b1;
      end else if (awaddr_r == `NVMAC_OFS_ADDR_LO) begin
         wr_hit = 1'b1;
      end else if (awaddr_r == `NVMAC_OFS_ADDR_HI) begin
         wr_hit = 1'b1;
      end else if (awaddr_r == `NVMAC_OFS_CTRL) begin
         wr_hit = 1'b1;
      end else if (awaddr_r == `NVMAC_OFS_KEY) begin
         wr_hit = 1'b1;
      end else if (awaddr_r == `NVMAC_OFS_STATUS) begin
         wr_hit = 1'b1;
      end else begin
         wr_hit = 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end
   assign ctrl_wr = wr_go && (awaddr_r == `NVMAC_OFS_CTRL) && wstrb_r[0];
   assign trig_set = ctrl_wr && wdata_r[`NVMAC_B_PROG] && !prog_r;
   // accepted only when unlocked, enabled and idle
   assign accept = trig_set && moden_r && (key_r == 2'd2)
      && (state_r == NVMAC_IDLE);

   // unlock key tracker: any other write breaks the sequence
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         key_r <= 2'd0;
      end else if (wr_go) begin
         if (awaddr_r == `NVMAC_OFS_KEY && wstrb_r[0]
             && wdata_r[7:0] == `NVMAC_KEY1) begin
            key_r <= 2'd1;
         end else if (awaddr_r == `NVMAC_OFS_KEY && wstrb_r[0] && key_r == 2'd1
             && wdata_r[7:0] == `NVMAC_KEY2) begin
            key_r <= 2'd2;
         end else begin
            key_r <= 2'd0;
         end
      end
   end

   // address registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_lo_r <= 8'h00;
         addr_hi_r <= 7'h00;
      end else if (wr_go && wstrb_r[0]) begin
         if (awaddr_r == `NVMAC_OFS_ADDR_LO) begin
            addr_lo_r <= wdata_r[7:0];
         end else if (awaddr_r == `NVMAC_OFS_ADDR_HI) begin
            addr_hi_r <= wdata_r[6:0];
         end
      end
   end

   // data registers: software write or fetch result
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_lo_r <= 8'h00;
         data_hi_r <= 6'h00;
      end else if (nvm_req_o.rd) begin
         // capture in the strobe cycle, when space and address on the request are current
         if (space == NVMAC_SP_ID && !id_ok_rd) begin
            data_lo_r <= 8'h00;
            data_hi_r <= 6'h00;
         end else begin
            data_lo_r <= nvm_rdata_i[7:0];
            data_hi_r <= nvm_rdata_i[13:8];
         end
      end else if (wr_go && wstrb_r[0]) begin
         if (awaddr_r == `NVMAC_OFS_DATA_LO) begin
            data_lo_r <= wdata_r[7:0];
         end else if (awaddr_r == `NVMAC_OFS_DATA_HI) begin
            data_hi_r <= wdata_r[5:0];
         end
      end
   end

   // control bits written by software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flash_r <= 1'b0;
         idsp_r <= 1'b0;
         latch_r <= 1'b0;
         moden_r <= 1'b0;
      end else if (ctrl_wr) begin
         flash_r <= wdata_r[`NVMAC_B_FLASH];
         idsp_r <= wdata_r[`NVMAC_B_IDSP];
         latch_r <= wdata_r[`NVMAC_B_LATCH];
         moden_r <= wdata_r[`NVMAC_B_MODEN];
      end
   end
   // erase select, cleared by hardware after an erase
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         erase_r <= 1'b0;
      end else if (state_r == NVMAC_DONE && !ee_r && !latch_only_r && erase_r) begin
         erase_r <= 1'b0;
      end else if (ctrl_wr) begin
         erase_r <= wdata_r[`NVMAC_B_ERASE];
      end
   end
   // fault flag: hardware set wins over software write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_r <= 1'b0;
      end else if (trig_set || (nvm_abort_i && state_r != NVMAC_IDLE)) begin
         fault_r <= 1'b1;
      end else if (ctrl_wr) begin
         fault_r <= wdata_r[`NVMAC_B_FAULT];
      end
   end
   // fetch trigger: set only, one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fetch_r <= 1'b0;
      end else if (fetch_r) begin
         fetch_r <= 1'b0;
      end else if (ctrl_wr && wdata_r[`NVMAC_B_FETCH] && state_r == NVMAC_IDLE) begin
         fetch_r <= 1'b1;
      end
   end

   // program sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= NVMAC_IDLE;
         cnt_r <= '0;
         prog_r <= 1'b0;
         arr_op_r <= 1'b0;
         latch_only_r <= 1'b0;
         ee_r <= 1'b0;
      end else begin
         case (state_r)
            NVMAC_IDLE: begin
               if (accept) begin
                  prog_r <= 1'b1;
                  ee_r <= (space == NVMAC_SP_EEPROM);
                  latch_only_r <= (space != NVMAC_SP_EEPROM) && latch_r;
                  arr_op_r <= !(space == NVMAC_SP_ID && !id_ok_wr);
                  cnt_r <= CW'(SETUP_CYC - 1);
                  state_r <= NVMAC_SETUP;
               end
            end
            NVMAC_SETUP: begin
               if (cnt_r != '0) begin
                  cnt_r <= cnt_r - 1'b1;
               end else if (latch_only_r || !arr_op_r) begin
                  state_r <= NVMAC_DONE;
               end else if (ee_r || erase_r) begin
                  cnt_r <= CW'(PROG_CYC - 1);
                  state_r <= NVMAC_ERASE;
               end else begin
                  cnt_r <= CW'(PROG_CYC - 1);
                  state_r <= NVMAC_WRITE;
               end
            end
            NVMAC_ERASE: begin
               if (nvm_abort_i) begin
                  state_r <= NVMAC_DONE;
               end else if (cnt_r != '0) begin
                  cnt_r <= cnt_r - 1'b1;
               end else if (ee_r) begin
                  cnt_r <= CW'(PROG_CYC - 1);
                  state_r <= NVMAC_WRITE;
               end else begin
                  state_r <= NVMAC_DONE;
               end
            end
            NVMAC_WRITE: begin
               if (nvm_abort_i || cnt_r == '0) begin
                  state_r <= NVMAC_DONE;
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            NVMAC_DONE: begin
               prog_r <= 1'b0;
               state_r <= NVMAC_IDLE;
            end
            default: begin
               state_r <= NVMAC_IDLE;
            end
         endcase
      end
   end

   // array request and cpu stall, registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nvm_req_o <= '0;
         cpu_stall_o <= 1'b0;
      end else begin
         nvm_req_o.rd <= fetch_r;
         nvm_req_o.latch <= (state_r == NVMAC_SETUP) && cnt_r == '0 && arr_op_r
            && (space != NVMAC_SP_EEPROM);
         nvm_req_o.erase <= (state_r == NVMAC_ERASE);
         nvm_req_o.write <= (state_r == NVMAC_WRITE);
         nvm_req_o.space <= space;
         nvm_req_o.addr <= addr;
         nvm_req_o.wdata <= {data_hi_r, data_lo_r};
         cpu_stall_o <= (state_r == NVMAC_ERASE) || (state_r == NVMAC_WRITE);
      end
   end

   // read decode
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 8'h00;
      if (s_axi_araddr == `NVMAC_OFS_DATA_LO) begin
         rd_val = data_lo_r;
      end else if (s_axi_araddr == `NVMAC_OFS_DATA_HI) begin
         rd_val = {2'b00, data_hi_r};
      end else if (s_axi_araddr == `NVMAC_OFS_ADDR_LO) begin
         rd_val = addr_lo_r;
      end else if (s_axi_araddr == `NVMAC_OFS_ADDR_HI) begin
         rd_val = {`NVMAC_ADDR_HI_TOP, addr_hi_r};
      end else if (s_axi_araddr == `NVMAC_OFS_CTRL) begin
         rd_val = {flash_r, idsp_r, latch_r, erase_r, fault_r, moden_r, prog_r, fetch_r};
      end else if (s_axi_araddr == `NVMAC_OFS_KEY) begin
         rd_val = 8'h00;
      end else if (s_axi_araddr == `NVMAC_OFS_STATUS) begin
         rd_val = {5'h00, state_r};
      end else begin
         rd_hit = 1'b0;
      end
   end
   // read channel
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_val};
            s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : nvmac_top

// ===== nvmac_array_model.sv
`timescale 1ns/1ns
module nvmac_array_model import nvmac_pkg::*; (
   input wire logic clk_i,
   input wire nvmac_req_s req_i,
   input wire logic abort_cmd_i,
   output logic [13:0] rdata_o,
   output logic abort_o
);
   logic [13:0] mem [logic [16:0]];
   logic [13:0] lat [logic [16:0]];
   logic er_q = 1'b0;
   logic wr_q = 1'b0;
   wire [16:0] k = {req_i.space, req_i.addr};
   // latch, erase and program cells; unwritten cells hold an address pattern
   always @(posedge clk_i) begin
      if (req_i.latch) lat[k] = req_i.wdata;
      if (req_i.erase && !er_q) mem[k] = 14'h3fff;
      if (req_i.write && !wr_q) begin
         lat[k] = req_i.wdata;
         foreach (lat[i]) mem[i] = lat[i];
         lat.delete();
      end
      er_q <= req_i.erase;
      wr_q <= req_i.write;
   end
   // read port settles mid-cycle from the request standing in that cycle
   always @(negedge clk_i) begin
      rdata_o <= mem.exists(k) ? mem[k] : k[13:0] ^ {k[16:15], 12'h555};
   end
   // abnormal end only when the bench asks for it
   assign abort_o = abort_cmd_i;
endmodule : nvmac_array_model

// ===== nvmac_top_sva.sv
`timescale 1ns/1ns
`include "nvmac_cfg.svh"
module nvmac_top_sva import nvmac_pkg::*; #(
   parameter int PROG_CYC = 20
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire nvmac_req_s nvm_req_o,
   input wire logic nvm_abort_i,
   input wire logic cpu_stall_o
);
   logic [7:0] aw_q, w_q, ar_q, ctl_q;
   logic [1:0] key_q;
   logic go_q, ab_q;
   logic [15:0] wcnt_q;
   wire busy = nvm_req_o.erase | nvm_req_o.write;
   wire wdone = s_axi_bvalid & s_axi_bready;
   wire ctl_wr = wdone && aw_q == `NVMAC_OFS_CTRL;
   wire [1:0] sp = ctl_q[6] ? 2'b10 : {1'b0, ctl_q[7]};
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // bus addresses and data as taken
   always_ff @(posedge clk_i) begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata[7:0];
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
   end
   // key sequence, armed trigger, abort memory, write length
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         key_q <= 2'd0;
         go_q <= 1'b0;
         ctl_q <= 8'h00;
      end else if (wdone) begin
         key_q <= (aw_q != `NVMAC_OFS_KEY) ? 2'd0 : (w_q == `NVMAC_KEY1) ? 2'd1 :
            (w_q == `NVMAC_KEY2 && key_q == 2'd1) ? 2'd2 : 2'd0;
         go_q <= ctl_wr && key_q == 2'd2 && ctl_q[2] && w_q[1];
         if (ctl_wr) ctl_q <= w_q;
      end else if (busy) go_q <= 1'b0;
      ab_q <= !rst_i && (nvm_abort_i || (ab_q && busy));
      wcnt_q <= (rst_i || !nvm_req_o.write) ? 16'd0 : wcnt_q + 16'd1;
   end
   sequence s_go;
      ##[0:4] go_q;
   endsequence
   sequence s_wr;
      ##[0:2] nvm_req_o.write;
   endsequence
   property p_dhi;
      s_axi_rvalid && ar_q == `NVMAC_OFS_DATA_HI |-> s_axi_rdata[31:6] == 26'h0;
   endproperty
   a_dhi: assert property (p_dhi) else $error("data high upper bits set");
   property p_ahi;
      s_axi_rvalid && ar_q == `NVMAC_OFS_ADDR_HI |-> s_axi_rdata[7];
   endproperty
   a_ahi: assert property (p_ahi) else $error("address high top bit low");
   property p_stall;
      cpu_stall_o |-> busy || $past(busy);
   endproperty
   a_stall: assert property (p_stall) else $error("stall without array op");
   property p_rd;
      $rose(nvm_req_o.rd) |=> !nvm_req_o.rd;
   endproperty
   a_rd: assert property (p_rd) else $error("read strobe too long");
   property p_keyed;
      $rose(busy) |-> s_go;
   endproperty
   a_keyed: assert property (p_keyed) else $error("array op without keys");
   property p_space;
      $rose(busy) |-> ##[0:4] nvm_req_o.space == sp;
   endproperty
   a_space: assert property (p_space) else $error("array op in wrong space");
   property p_ee;
      $fell(nvm_req_o.erase) && nvm_req_o.space == NVMAC_SP_EEPROM && !ab_q |-> s_wr;
   endproperty
   a_ee: assert property (p_ee) else $error("eeprom erase not followed by write");
   property p_wlen;
      $fell(nvm_req_o.write) && !ab_q |-> wcnt_q >= PROG_CYC;
   endproperty
   a_wlen: assert property (p_wlen) else $error("program phase too short");
endmodule : nvmac_top_sva
bind nvmac_top nvmac_top_sva #(.PROG_CYC(PROG_CYC)) u_nvmac_top_sva (.clk_i, .rst_i,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .nvm_req_o, .nvm_abort_i, .cpu_stall_o);

// ===== test_nvmac_top.sv
`timescale 1ns/1ns
`include "nvmac_cfg.svh"
module test_nvmac_top import nvmac_pkg::*;;
   typedef struct {string nm; logic [31:0] e; logic [31:0] m; logic [1:0] r;} nvmac_note_s;
   localparam logic [7:0] CT = `NVMAC_OFS_CTRL;
   logic clk_i = 1'b0, rst_i = 1'b1, abort_cmd = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   nvmac_req_s nvm_req_o;
   logic [13:0] nvm_rdata_i;
   logic nvm_abort_i, cpu_stall_o;
   nvmac_note_s q[$];
   logic [1:0] bq[$];
   logic [13:0] em [logic [16:0]];
   int err_count = 0, n_checks = 0, cyc = 0;
   nvmac_top #(.PROG_CYC(20), .SETUP_CYC(2)) u_nvmac_top (.clk_i, .rst_i, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nvm_req_o,
      .nvm_rdata_i, .nvm_abort_i, .cpu_stall_o);
   nvmac_array_model u_nvmac_array_model (.clk_i, .req_i(nvm_req_o), .abort_cmd_i(abort_cmd),
      .rdata_o(nvm_rdata_i), .abort_o(nvm_abort_i));
   always #25 clk_i = ~clk_i;
   task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic end_of_test();
      if (err_count == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test
   // result watcher, oldest note first
   always @(posedge clk_i) begin
      if (s_axi_rvalid && s_axi_rready) begin
         chk(q[0].nm, {s_axi_rresp, s_axi_rdata & q[0].m}, {q[0].r, q[0].e & q[0].m});
         q.delete(0);
      end
      if (s_axi_bvalid && s_axi_bready) begin
         chk("bresp", {32'h0, s_axi_bresp}, {32'h0, bq[0]});
         bq.delete(0);
      end
   end
   // hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ta, tw;
      bq.push_back((a > `NVMAC_OFS_STATUS || a[1:0] != 2'b00) ? 2'b10 : 2'b00);
      ta = 1'b0;
      tw = 1'b0;
      @(posedge clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ta && tw)) begin
         @(posedge clk_i);
         ta = ta | s_axi_awready;
         tw = tw | s_axi_wready;
         s_axi_awvalid <= !ta;
         s_axi_wvalid <= !tw;
      end
      do @(posedge clk_i); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m, input logic [1:0] r);
      q.push_back('{nm, e, m, r});
      @(posedge clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_i); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_i); while (!s_axi_rvalid);
      rdv = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask : rc
   function automatic logic [16:0] key(input logic [7:0] c, input logic [14:0] a);
      return {c[6], !c[6] && c[7], a};
   endfunction : key
   function automatic logic [13:0] ev(input logic [16:0] k);
      if (em.exists(k)) return em[k];
      return k[13:0] ^ {k[16:15], 12'h555};
   endfunction : ev
   task automatic setad(input logic [14:0] a);
      wr(`NVMAC_OFS_ADDR_LO, a[7:0]);
      wr(`NVMAC_OFS_ADDR_HI, {1'b0, a[14:8]});
   endtask : setad
   task automatic fchk(input logic [7:0] c, input logic [14:0] a, input logic [13:0] e);
      setad(a);
      wr(CT, c | 8'h01);
      rc("fetch", CT, 0, 1, 0);
      rc("data_lo", `NVMAC_OFS_DATA_LO, {24'h0, e[7:0]}, '1, 0);
      rc("data_hi", `NVMAC_OFS_DATA_HI, {26'h0, e[13:8]}, '1, 0);
   endtask : fchk
   task automatic prog(input logic [7:0] c, input logic [14:0] a, input logic [13:0] d,
      input logic keys, input logic op, input logic abt);
      int n;
      setad(a);
      wr(`NVMAC_OFS_DATA_LO, d[7:0]);
      wr(`NVMAC_OFS_DATA_HI, {2'b0, d[13:8]});
      wr(CT, c & 8'hf5);
      if (keys) begin
         wr(`NVMAC_OFS_KEY, `NVMAC_KEY1);
         wr(`NVMAC_OFS_KEY, `NVMAC_KEY2);
      end
      wr(CT, c);
      rc("trig", CT, 32'h0a, op ? 32'h0a : 32'h08, 0);
      if (op) begin
         wr(CT, c & 8'hf5);
         rc("hold", CT, 32'h02, 32'h02, 0);
         abort_cmd <= abt;
         @(posedge clk_i);
         abort_cmd <= 1'b0;
      end
      n = 0;
      do begin
         rc("poll", CT, 0, 0, 0);
         n++;
      end while (rdv[1] && n < 100);
      rc("done", CT, {28'h0, !(op && !abt), 3'b0}, {27'h0, c[4] & c[7], 4'ha}, 0);
   endtask : prog
   // main sequence
   initial begin
      logic [14:0] a;
      logic [13:0] d;
      logic [31:0] r;
      void'($urandom(32'h63e6));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rc("ctrl_rst", CT, {24'h0, `NVMAC_RST_CTRL}, '1, 0);
      rc("ahi_rst", `NVMAC_OFS_ADDR_HI, 32'h80, '1, 0);
      rc("hole", 8'h1c, 0, '1, 2'b10);
      wr(8'h1c, 8'h00);
      r = $urandom;
      wr(`NVMAC_OFS_ADDR_HI, r[7:0]);
      rc("ahi", `NVMAC_OFS_ADDR_HI, {24'h0, 1'b1, r[6:0]}, '1, 0);
      wr(`NVMAC_OFS_DATA_HI, r[15:8]);
      rc("dhi", `NVMAC_OFS_DATA_HI, {26'h0, r[13:8]}, '1, 0);
      for (int i = 0; i < 10; i++) begin
         a = i[14:0];
         fchk(8'h40, a, (i < 4 || (i > 5 && i < 9)) ? ev(key(8'h40, a)) : 14'h0);
      end
      a = 15'($urandom);
      d = 14'($urandom);
      fchk(8'h00, a, ev(key(8'h00, a)));
      fchk(8'h80, a, ev(key(8'h80, a)));
      prog(8'h36, a, d, 1, 1, 0);
      em[key(8'h00, a)] = d;
      fchk(8'h00, a, d);
      prog(8'h06, a, ~d, 0, 0, 0);
      prog(8'h02, a, ~d, 1, 0, 0);
      fchk(8'h00, a, d);
      prog(8'ha6, a, d, 1, 0, 0);
      prog(8'h86, a + 15'd1, ~d, 1, 1, 0);
      em[key(8'h80, a)] = d;
      em[key(8'h80, a + 15'd1)] = ~d;
      fchk(8'h80, a, d);
      fchk(8'h80, a + 15'd1, ~d);
      prog(8'h96, a, 14'h0, 1, 1, 0);
      fchk(8'h80, a, 14'h3fff);
      prog(8'h46, 15'h1, d, 1, 1, 0);
      fchk(8'h40, 15'h1, d);
      prog(8'h46, 15'h7, d, 1, 0, 0);
      fchk(8'h40, 15'h7, ev(key(8'h40, 15'h7)));
      prog(8'h06, a, d, 1, 1, 1);
      end_of_test();
   end
endmodule : test_nvmac_top
